// ===== core/tpu_top.sv
`timescale 1ns/100ps
// Contract
// - Mode bit 0 timer, 1 PWM
// - Clock, clear, run; unit 0 may use pins
// - Counter increments on each prescaler edge
// - 16-bit prescaler divides selected clock source
// - Clear signal zeroes the 8-bit counter
// - Mask bit set holds unit in clear
// - Run gate stops counting; internal bit forces
// - Level mode: count while high, capture on fall
// - Edge mode: measure one pin period
// - Timer output frequency is prescaler over compare
// - Shape bit: square or one-period pulse
// - True and inverted pins, each enabled
// - PWM restart loads reload value
// - PWM output falls when count equals compare
// - Period 255 minus reload; high compare minus reload
// - Compare 255 high; 0 or below reload low
// - New compare applies at cycle end, or at once while the unit is cleared
// - New reload applies at the next restart
// - PWM stop holds output level
// - Cleared unit or reset floats pins
// - Divider code n divides by two to n; codes above 16 divide by two to 16
// - Edge select bit: 0 level, 1 edge
module tpu_top
   import tpu_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Unit 0 external sources
   input wire logic unit0_clear_pin,
   input wire logic unit0_run_pin,
   input wire logic unit0_clock_pin,
   // Output pins, enables active low
   output logic [UNITS-1:0] output_pin,
   output logic [UNITS-1:0] output_pin_oe_n,
   output logic [UNITS-1:0] output_pin_inv,
   output logic [UNITS-1:0] output_pin_inv_oe_n
);
   // ------------------------------------------------------------
   // Registers and state
   // ------------------------------------------------------------
   tpu_unit_cfg_s cfg_q [UNITS];
   logic [7:0] src_q;
   logic [7:0] pin_q;
   logic [UNITS-1:0][CNT_W-1:0] cnt_q;
   logic [UNITS-1:0][CNT_W-1:0] cmp_act_q;
   logic [UNITS-1:0][PRE_W-1:0] pre_q;
   logic [UNITS-1:0] wave_q;
   logic [CNT_W-1:0] cap_q;
   logic run_pin_prev_q;
   logic clk_pin_prev_q;
   tpu_edge_e edge_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic [UNITS-1:0] pin_oe_n_q;
   logic [UNITS-1:0] pin_inv_oe_n_q;
   logic [UNITS-1:0] pin_out_q;
   logic [UNITS-1:0] pin_inv_q;

   logic [UNITS-1:0] clr;
   logic [UNITS-1:0] run;
   logic [UNITS-1:0] tick;
   logic [UNITS-1:0] pulse;
   logic ext_run;
   logic run_rise;
   logic run_fall;
   logic [IDX_W-1:0] idx;
   logic hit;
   logic [31:0] rdata;
   logic wr_en;

   // Divide by two to the code; codes above the top divide by the top
   function automatic logic [PRE_W-1:0] div_mask(input logic [SEL_W-1:0] sel);
      logic [PRE_W-1:0] m;
      m = PRE_ALL;
      if (sel < SEL_MAX) begin
         m = (PRE_ONE << sel) - PRE_ONE;
      end
      return m;
   endfunction : div_mask

   // ------------------------------------------------------------
   // Unit 0 source selection
   // ------------------------------------------------------------
   assign run_rise = unit0_run_pin & ~run_pin_prev_q;
   assign run_fall = ~unit0_run_pin & run_pin_prev_q;
   assign ext_run = cfg_q[0].edge_sel ? (edge_q == ES_RUN) : unit0_run_pin;

   always_comb begin
      for (int u = 0; u < UNITS; u++) begin
         clr[u] = ~cfg_q[u].iclr | src_q[SRC_MSK_BIT[u]];
         run[u] = cfg_q[u].irun;
         tick[u] = 1'b1;
         pulse[u] = tick[u] & ((pre_q[u] & div_mask(cfg_q[u].dsel)) == div_mask(cfg_q[u].dsel));
      end
      if (src_q[SRC_CLR_LSB +: 2] == SRC_EXT) begin
         clr[0] = unit0_clear_pin | src_q[SRC_MSK_BIT[0]];
      end else if (src_q[SRC_CLR_LSB +: 2] == SRC_BOTH) begin
         clr[0] = unit0_clear_pin | ~cfg_q[0].iclr | src_q[SRC_MSK_BIT[0]];
      end
      if (src_q[SRC_RUN_LSB +: 2] == SRC_EXT) begin
         run[0] = ext_run;
      end else if (src_q[SRC_RUN_LSB +: 2] == SRC_BOTH) begin
         run[0] = ext_run | cfg_q[0].irun;
      end
      // Pin clock must be under half pclk or edges are missed
      if (src_q[SRC_CLK_BIT]) begin
         tick[0] = unit0_clock_pin & ~clk_pin_prev_q;
      end
      pulse[0] = tick[0] & ((pre_q[0] & div_mask(cfg_q[0].dsel)) == div_mask(cfg_q[0].dsel));
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_pin_prev_q <= 1'b0;
         clk_pin_prev_q <= 1'b0;
      end else begin
         run_pin_prev_q <= unit0_run_pin;
         clk_pin_prev_q <= unit0_clock_pin;
      end
   end

   // ------------------------------------------------------------
   // Edge measurement and capture
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         edge_q <= ES_IDLE;
      end else if (clr[0]) begin
         edge_q <= ES_IDLE;
      end else begin
         case (edge_q)
            ES_IDLE: if (run_rise) edge_q <= ES_RUN;
            ES_RUN: if (run_rise) edge_q <= ES_DONE;
            ES_DONE: edge_q <= ES_DONE;
            default: edge_q <= ES_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_q <= CNT_ZERO;
      end else if (!cfg_q[0].edge_sel && run_fall) begin
         cap_q <= cnt_q[0];
      end else if (cfg_q[0].edge_sel && edge_q == ES_RUN && run_rise) begin
         cap_q <= cnt_q[0];
      end
   end

   // ------------------------------------------------------------
   // Prescaler, counter and waveform per unit
   // ------------------------------------------------------------
   for (genvar u = 0; u < UNITS; u++) begin : g_unit
      logic [CNT_W-1:0] nxt;
      logic [CNT_W:0] half;
      logic pwm_on;
      assign nxt = cnt_q[u] + CNT_ONE;
      assign half = ({1'b0, cmp_act_q[u]} + 9'h001) >> 1;
      assign pwm_on = (cfg_q[u].cmp == CNT_MAX) || (cfg_q[u].cmp > cfg_q[u].reload);

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            pre_q[u] <= '0;
         end else if (clr[u]) begin
            pre_q[u] <= '0;
         end else if (tick[u]) begin
            pre_q[u] <= pre_q[u] + PRE_ONE;
         end
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            cnt_q[u] <= CNT_ZERO;
            cmp_act_q[u] <= CNT_ZERO;
            wave_q[u] <= 1'b0;
         end else if (clr[u]) begin
            cnt_q[u] <= CNT_ZERO;
            cmp_act_q[u] <= cfg_q[u].cmp;
            wave_q[u] <= 1'b0;
         end else if (pulse[u] && run[u]) begin
            if (cfg_q[u].mode == MODE_PWM) begin
               // Restart early so period is 255 minus reload
               if (cnt_q[u] >= PWM_TOP) begin
                  cnt_q[u] <= cfg_q[u].reload;
                  cmp_act_q[u] <= cfg_q[u].cmp;
                  wave_q[u] <= pwm_on;
               end else begin
                  cnt_q[u] <= nxt;
                  if (nxt == cmp_act_q[u] && cmp_act_q[u] != CNT_MAX) begin
                     wave_q[u] <= 1'b0;
                  end
               end
            end else if (cmp_act_q[u] != CNT_ZERO && nxt == cmp_act_q[u]) begin
               cnt_q[u] <= CNT_ZERO;
               cmp_act_q[u] <= cfg_q[u].cmp;
               wave_q[u] <= (cfg_q[u].shape == SHAPE_SQUARE) ? (half != 9'h000) : 1'b1;
            end else begin
               cnt_q[u] <= nxt;
               if (cmp_act_q[u] == CNT_ZERO) begin
                  wave_q[u] <= 1'b0;
               end else if (cfg_q[u].shape == SHAPE_SQUARE) begin
                  wave_q[u] <= ({1'b0, nxt} < half);
               end else begin
                  wave_q[u] <= 1'b0;
               end
            end
         end
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            pin_oe_n_q[u] <= 1'b1;
            pin_inv_oe_n_q[u] <= 1'b1;
            pin_out_q[u] <= 1'b0;
            pin_inv_q[u] <= 1'b0;
         end else begin
            pin_oe_n_q[u] <= clr[u] | ~pin_q[PIN_TRUE_BIT[u]];
            pin_inv_oe_n_q[u] <= clr[u] | ~pin_q[PIN_COMP_BIT[u]];
            pin_out_q[u] <= wave_q[u];
            pin_inv_q[u] <= ~wave_q[u];
         end
      end

      // Checks
      mask_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
         src_q[SRC_MSK_BIT[u]] |=> cnt_q[u] == CNT_ZERO && pin_oe_n_q[u])
         else $error("masked unit not held clear");
      clear_float_a: assert property (@(posedge pclk) disable iff (!presetn)
         clr[u] |=> pin_oe_n_q[u] && pin_inv_oe_n_q[u])
         else $error("cleared unit drives pins");
      count_step_a: assert property (@(posedge pclk) disable iff (!presetn)
         !clr[u] && run[u] && pulse[u] && cfg_q[u].mode != MODE_PWM
         && cmp_act_q[u] == CNT_ZERO |=> cnt_q[u] == $past(cnt_q[u]) + CNT_ONE)
         else $error("counter did not advance on prescaler edge");
      timer_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
         !clr[u] && !run[u] |=> $stable(cnt_q[u]))
         else $error("counter moved while stopped");
      pwm_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
         !clr[u] && !run[u] && cfg_q[u].mode == MODE_PWM [*2] |-> $stable(wave_q[u]))
         else $error("stopped PWM output changed");
      cmp_defer_a: assert property (@(posedge pclk) disable iff (!presetn)
         !clr[u] && !(pulse[u] && run[u]) |=> $stable(cmp_act_q[u]))
         else $error("compare changed mid cycle");

      sequence pwm_restart_s;
         !clr[u] && run[u] && pulse[u] && cfg_q[u].mode == MODE_PWM && cnt_q[u] >= PWM_TOP;
      endsequence
      sequence pwm_match_s;
         !clr[u] && run[u] && pulse[u] && cfg_q[u].mode == MODE_PWM && cnt_q[u] < PWM_TOP
         && cnt_q[u] + CNT_ONE == cmp_act_q[u];
      endsequence
      pwm_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
         pwm_restart_s |=> cnt_q[u] == $past(cfg_q[u].reload))
         else $error("PWM restart did not load reload");
      pwm_level_a: assert property (@(posedge pclk) disable iff (!presetn)
         pwm_restart_s |=> wave_q[u] == ($past(cfg_q[u].cmp) == CNT_MAX
         || $past(cfg_q[u].cmp) > $past(cfg_q[u].reload)))
         else $error("PWM restart level wrong");
      pwm_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
         pwm_match_s |=> !wave_q[u])
         else $error("PWM output did not fall at compare");
   end : g_unit

   level_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
      !cfg_q[0].edge_sel && run_fall |=> cap_q == $past(cnt_q[0]))
      else $error("level capture missed");
   edge_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
      !clr[0] && edge_q == ES_RUN && run_rise |=> edge_q == ES_DONE)
      else $error("edge measurement did not stop");

   // ------------------------------------------------------------
   // APB slave: answer prepared in setup, so no wait states
   // ------------------------------------------------------------
   assign idx = paddr[ADDR_W-1:2];
   assign wr_en = psel & penable & pready_q & pwrite & ~pslverr_q;

   always_comb begin
      hit = 1'b0;
      rdata = WORD_ZERO;
      if (paddr[1:0] != 2'h0) begin
         hit = 1'b0;
      end else if (idx == IDX_SRC) begin
         hit = 1'b1;
         rdata = {24'h000000, src_q};
      end else if (idx == IDX_PIN) begin
         hit = 1'b1;
         rdata = {24'h000000, pin_q};
      end else begin
         for (int u = 0; u < UNITS; u++) begin
            if (idx == IDX_CMP[u]) begin
               hit = 1'b1;
            end else if (idx == IDX_RLD[u]) begin
               hit = 1'b1;
               rdata = {24'h000000, cfg_q[u].reload};
            end else if (idx == IDX_CTRL[u]) begin
               hit = 1'b1;
               rdata[CTRL_CLR_BIT] = cfg_q[u].iclr;
               rdata[CTRL_RUN_BIT] = cfg_q[u].irun;
               rdata[CTRL_EDGE_BIT] = cfg_q[u].edge_sel;
               rdata[CTRL_MODE_BIT] = cfg_q[u].mode;
            end else if (idx == IDX_DIV[u]) begin
               hit = 1'b1;
               rdata[DIV_SEL_LSB +: SEL_W] = cfg_q[u].dsel;
               rdata[DIV_SHAPE_BIT] = cfg_q[u].shape;
            end else if (idx == IDX_CNT[u]) begin
               hit = 1'b1;
               rdata = {24'h000000, cnt_q[u]};
               if (u == 0 && src_q[SRC_RUN_LSB +: 2] != SRC_INT) begin
                  rdata = {24'h000000, cap_q};
               end
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= WORD_ZERO;
      end else if (psel && !penable) begin
         pready_q <= 1'b1;
         pslverr_q <= ~hit | (pwrite & (idx == IDX_CNT[0] || idx == IDX_CNT[1]
            || idx == IDX_CNT[2]));
         prdata_q <= pwrite ? WORD_ZERO : rdata;
      end else begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= WORD_ZERO;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_q <= BYTE_ZERO;
         pin_q <= BYTE_ZERO;
         for (int u = 0; u < UNITS; u++) begin
            cfg_q[u] <= '0;
         end
      end else if (wr_en) begin
         if (idx == IDX_SRC) begin
            src_q <= pwdata[7:0];
         end else if (idx == IDX_PIN) begin
            pin_q <= pwdata[7:0];
         end else begin
            for (int u = 0; u < UNITS; u++) begin
               if (idx == IDX_CMP[u]) begin
                  cfg_q[u].cmp <= pwdata[CNT_W-1:0];
               end else if (idx == IDX_RLD[u]) begin
                  cfg_q[u].reload <= pwdata[CNT_W-1:0];
               end else if (idx == IDX_CTRL[u]) begin
                  cfg_q[u].iclr <= pwdata[CTRL_CLR_BIT];
                  cfg_q[u].irun <= pwdata[CTRL_RUN_BIT];
                  cfg_q[u].edge_sel <= pwdata[CTRL_EDGE_BIT];
                  cfg_q[u].mode <= pwdata[CTRL_MODE_BIT];
               end else if (idx == IDX_DIV[u]) begin
                  cfg_q[u].dsel <= pwdata[DIV_SEL_LSB +: SEL_W];
                  cfg_q[u].shape <= pwdata[DIV_SHAPE_BIT];
               end
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign output_pin = pin_out_q;
   assign output_pin_oe_n = pin_oe_n_q;
   assign output_pin_inv = pin_inv_q;
   assign output_pin_inv_oe_n = pin_inv_oe_n_q;
endmodule : tpu_top

// ===== common/tpu_pkg.sv
package tpu_pkg;
   // ------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------
   localparam int UNITS = 3;
   localparam int CNT_W = 8;
   localparam int PRE_W = 16;
   localparam int SEL_W = 5;
   localparam int ADDR_W = 8;
   localparam int IDX_W = 6;

   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [IDX_W-1:0] IDX_CMP [UNITS] = '{6'h03, 6'h05, 6'h07};
   localparam logic [IDX_W-1:0] IDX_RLD [UNITS] = '{6'h04, 6'h06, 6'h08};
   localparam logic [IDX_W-1:0] IDX_CTRL [UNITS] = '{6'h09, 6'h0a, 6'h0b};
   localparam logic [IDX_W-1:0] IDX_DIV [UNITS] = '{6'h0c, 6'h0d, 6'h0e};
   localparam logic [IDX_W-1:0] IDX_SRC = 6'h0f;
   localparam logic [IDX_W-1:0] IDX_PIN = 6'h10;
   localparam logic [IDX_W-1:0] IDX_CNT [UNITS] = '{6'h11, 6'h12, 6'h13};

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CTRL_CLR_BIT = 0;
   localparam int CTRL_RUN_BIT = 2;
   localparam int CTRL_EDGE_BIT = 3;
   localparam int CTRL_MODE_BIT = 7;
   localparam int DIV_SEL_LSB = 0;
   localparam int DIV_SHAPE_BIT = 5;
   localparam int SRC_CLR_LSB = 0;
   localparam int SRC_RUN_LSB = 2;
   localparam int SRC_CLK_BIT = 4;
   localparam int SRC_MSK_BIT [UNITS] = '{5, 7, 6};
   localparam int PIN_TRUE_BIT [UNITS] = '{0, 2, 4};
   localparam int PIN_COMP_BIT [UNITS] = '{1, 3, 5};

   // ------------------------------------------------------------
   // Encodings and values
   // ------------------------------------------------------------
   localparam logic [1:0] SRC_INT = 2'h0;
   localparam logic [1:0] SRC_EXT = 2'h1;
   localparam logic [1:0] SRC_BOTH = 2'h2;
   localparam logic MODE_PWM = 1'b1;
   localparam logic SHAPE_SQUARE = 1'b1;
   localparam logic [SEL_W-1:0] SEL_MAX = 5'h10;
   localparam logic [PRE_W-1:0] PRE_ONE = 16'h0001;
   localparam logic [PRE_W-1:0] PRE_ALL = 16'hffff;
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
   localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;
   localparam logic [CNT_W-1:0] PWM_TOP = 8'hfe;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   typedef enum logic [2:0] {
      ES_IDLE = 3'b001,
      ES_RUN = 3'b010,
      ES_DONE = 3'b100
   } tpu_edge_e;

   typedef struct packed {
      logic mode;
      logic iclr;
      logic irun;
      logic edge_sel;
      logic [SEL_W-1:0] dsel;
      logic shape;
      logic [CNT_W-1:0] reload;
      logic [CNT_W-1:0] cmp;
   } tpu_unit_cfg_s;
endpackage : tpu_pkg

// ===== testbench/tpu_pin_model.sv
`timescale 1ns/100ps
module tpu_pin_model
   import tpu_pkg::*;
(
   // Clock
   input wire logic pclk,
   // Bench commands
   input wire logic run_lvl,
   input wire logic clr_lvl,
   input wire logic clk_en,
   // Device pins
   input wire logic [UNITS-1:0] output_pin,
   input wire logic [UNITS-1:0] output_pin_oe_n,
   input wire logic [UNITS-1:0] output_pin_inv,
   input wire logic [UNITS-1:0] output_pin_inv_oe_n,
   output logic unit0_clear_pin,
   output logic unit0_run_pin,
   output logic unit0_clock_pin,
   // Board levels
   output logic [UNITS-1:0] pad,
   output logic [UNITS-1:0] pad_inv
);
   logic [1:0] ph_q;

   // Pull-down on the board, so a floating pin reads low
   assign pad = output_pin & ~output_pin_oe_n;
   assign pad_inv = output_pin_inv & ~output_pin_inv_oe_n;

   initial begin
      ph_q = 2'h0;
      unit0_clear_pin = 1'b0;
      unit0_run_pin = 1'b0;
      unit0_clock_pin = 1'b0;
   end

   always @(posedge pclk) begin
      unit0_run_pin <= run_lvl;
      unit0_clear_pin <= clr_lvl;
      ph_q <= ph_q + 2'h1;
      // Quarter rate, safely below half the master clock; still when off
      unit0_clock_pin <= clk_en & ph_q[1];
   end
endmodule : tpu_pin_model

// ===== testbench/test_timer_pwm_unit.sv
`timescale 1ns/100ps
module test_timer_pwm_unit
   import tpu_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic run_lvl, clr_lvl, clk_en, u0_clr, u0_run, u0_clk;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, q, a;
   logic [UNITS-1:0] opin, opin_oe_n, opin_inv, opin_inv_oe_n, pad, pad_inv;
   int err_count, num_checks, cyc, hi, per;

   tpu_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .unit0_clear_pin(u0_clr), .unit0_run_pin(u0_run),
      .unit0_clock_pin(u0_clk), .output_pin(opin), .output_pin_oe_n(opin_oe_n),
      .output_pin_inv(opin_inv), .output_pin_inv_oe_n(opin_inv_oe_n));

   tpu_pin_model i_pins (.pclk(pclk), .run_lvl(run_lvl), .clr_lvl(clr_lvl),
      .clk_en(clk_en), .output_pin(opin), .output_pin_oe_n(opin_oe_n),
      .output_pin_inv(opin_inv), .output_pin_inv_oe_n(opin_inv_oe_n),
      .unit0_clear_pin(u0_clr), .unit0_run_pin(u0_run), .unit0_clock_pin(u0_clk),
      .pad(pad), .pad_inv(pad_inv));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic chk_rng(input string nm, input int lo, input int hi_lim, input logic [31:0] got);
      num_checks++;
      if ($isunknown(got) || got < lo || got > hi_lim) begin
         err_count++;
         $display("mismatch %s expected %0d to %0d seen %h", nm, lo, hi_lim, got);
      end
   endtask : chk_rng

   // Period and high time from one rising edge of the pad to the next
   task automatic meas(input int u);
      logic prev;
      while (pad[u] !== 1'b0) @(negedge pclk);
      while (pad[u] !== 1'b1) @(negedge pclk);
      hi = 1;
      per = 0;
      prev = 1'b1;
      do begin
         @(negedge pclk);
         per++;
         if (pad[u] === 1'b1 && prev === 1'b0) break;
         if (pad[u] === 1'b1) hi++;
         prev = pad[u];
      end while (1);
      chk("inv_pin", 32'h0, {31'h0, pad_inv[u]});
   endtask : meas

   task automatic hold(input int u, input logic v);
      int n;
      n = 0;
      repeat (40) begin
         @(negedge pclk);
         if (pad[u] !== v) n++;
      end
      chk("steady", 32'h0, n);
   endtask : hold

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      @(negedge pclk);
      chk("oe_n", 32'h3f, {26'h0, opin_oe_n, opin_inv_oe_n});
      apb(1'b0, IDX_CTRL[0], 8'h00);
      chk("ctrl0", 32'h0, q);
      apb(1'b0, IDX_CMP[1], 8'h00);
      chk("cmp_read", 32'h0, q);
      apb(1'b0, 6'h3f, 8'h00);
      chk("unmapped", 32'h1, {31'h0, e});
      apb(1'b1, IDX_CNT[0], 8'h55);
      chk("cnt_write", 32'h1, {31'h0, e});
      $display("test reset done");
   endtask : t_reset

   task automatic t_pwm();
      apb(1'b1, IDX_PIN, 8'h3c);
      apb(1'b1, IDX_RLD[1], 8'hf0);
      apb(1'b1, IDX_CMP[1], 8'hf8);
      apb(1'b1, IDX_CTRL[1], 8'h85);
      meas(1);
      chk("period", 32'h0f, per);
      chk("high", 32'h08, hi);
      apb(1'b1, IDX_RLD[1], 8'he0);
      apb(1'b1, IDX_CMP[1], 8'hfc);
      meas(1);
      meas(1);
      chk("period2", 32'h1f, per);
      chk("high2", 32'h1c, hi);
      apb(1'b1, IDX_CMP[1], 8'hff);
      repeat (40) @(posedge pclk);
      hold(1, 1'b1);
      apb(1'b1, IDX_CMP[1], 8'h00);
      repeat (40) @(posedge pclk);
      hold(1, 1'b0);
      apb(1'b1, IDX_CMP[1], 8'hf8);
      meas(1);
      apb(1'b1, IDX_CTRL[1], 8'h81);
      hold(1, 1'b1);
      $display("test pwm done");
   endtask : t_pwm

   task automatic t_timer();
      apb(1'b1, IDX_CMP[2], 8'h04);
      apb(1'b1, IDX_DIV[2], 8'h20);
      apb(1'b1, IDX_CTRL[2], 8'h05);
      meas(2);
      meas(2);
      chk("tm_period", 32'h04, per);
      chk("tm_square", 32'h02, hi);
      apb(1'b1, IDX_DIV[2], 8'h00);
      meas(2);
      meas(2);
      chk("tm_pulse", 32'h01, hi);
      apb(1'b1, IDX_CMP[2], 8'h00);
      apb(1'b1, IDX_DIV[2], 8'h02);
      // Let the old compare wrap first so the new one is in force
      repeat (20) @(posedge pclk);
      apb(1'b0, IDX_CNT[2], 8'h00);
      a = q;
      repeat (61) @(posedge pclk);
      apb(1'b0, IDX_CNT[2], 8'h00);
      chk("rate", 32'h10, {24'h0, q[7:0] - a[7:0]});
      apb(1'b1, IDX_CTRL[2], 8'h01);
      apb(1'b0, IDX_CNT[2], 8'h00);
      a = q;
      repeat (20) @(posedge pclk);
      apb(1'b0, IDX_CNT[2], 8'h00);
      chk("stopped", a, q);
      apb(1'b1, IDX_SRC, 8'hc0);
      repeat (3) @(posedge pclk);
      apb(1'b0, IDX_CNT[2], 8'h00);
      chk("masked_cnt", 32'h0, q);
      @(negedge pclk);
      chk("masked_oe", 32'h3, {30'h0, opin_oe_n[1], opin_inv_oe_n[1]});
      apb(1'b1, IDX_SRC, 8'h00);
      $display("test timer done");
   endtask : t_timer

   task automatic t_ext();
      apb(1'b1, IDX_SRC, 8'h04);
      apb(1'b1, IDX_CMP[0], 8'h00);
      apb(1'b1, IDX_CTRL[0], 8'h01);
      run_lvl <= 1'b1;
      repeat (20) @(posedge pclk);
      run_lvl <= 1'b0;
      repeat (5) @(posedge pclk);
      apb(1'b0, IDX_CNT[0], 8'h00);
      chk_rng("level_cnt", 16, 24, q);
      a = q;
      repeat (10) @(posedge pclk);
      apb(1'b0, IDX_CNT[0], 8'h00);
      chk("level_hold", a, q);
      apb(1'b1, IDX_CTRL[0], 8'h08);
      apb(1'b1, IDX_CTRL[0], 8'h09);
      repeat (2) begin
         run_lvl <= 1'b1;
         repeat (3) @(posedge pclk);
         run_lvl <= 1'b0;
         repeat (27) @(posedge pclk);
      end
      apb(1'b0, IDX_CNT[0], 8'h00);
      chk_rng("edge_cnt", 26, 34, q);
      apb(1'b1, IDX_SRC, 8'h10);
      apb(1'b1, IDX_CTRL[0], 8'h05);
      clk_en <= 1'b1;
      apb(1'b0, IDX_CNT[0], 8'h00);
      a = q;
      repeat (61) @(posedge pclk);
      apb(1'b0, IDX_CNT[0], 8'h00);
      chk("ext_clk", 32'h10, {24'h0, q[7:0] - a[7:0]});
      $display("test external done");
   endtask : t_ext

   // Software start of all units at one edge through the masks
   task automatic t_sync();
      apb(1'b1, IDX_DIV[2], 8'h00);
      for (int u = 0; u < UNITS; u++) apb(1'b1, IDX_CTRL[u], 8'h00);
      apb(1'b1, IDX_SRC, 8'he0);
      for (int u = 0; u < UNITS; u++) apb(1'b1, IDX_CTRL[u], 8'h05);
      apb(1'b1, IDX_SRC, 8'h00);
      apb(1'b0, IDX_CNT[1], 8'h00);
      a = q;
      apb(1'b0, IDX_CNT[2], 8'h00);
      // Reads are three cycles apart, so equal starts differ by three
      chk("sync", 32'h03, {24'h0, q[7:0] - a[7:0]});
      $display("test sync done");
   endtask : t_sync

   // ------------------------------------------------------------
   // Run control
   // ------------------------------------------------------------
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : give_verdict

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // Whole run needs between one and two thousand cycles
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         give_verdict();
      end
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = WORD_ZERO;
      run_lvl = 1'b0;
      clr_lvl = 1'b0;
      clk_en = 1'b0;
      err_count = 0;
      num_checks = 0;
      cyc = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_pwm();
      t_timer();
      t_ext();
      t_sync();
      give_verdict();
   end
endmodule : test_timer_pwm_unit
